/* File: rtl/sbsi_sram_if.sv */
// SRAM-type system bus master for one bank: lane steering, size code,
// bank decode, fixed-wait and acknowledge-handshake cycles with bursts.
// Assumes one request at a time from the internal side and inputs
// synchronous to clk; the bus clock is sampled as an ordinary input.
`timescale 1ns/1ps
`default_nettype none
`include "sbsi_consts.svh"

module sbsi_sram_if
    import sbsi_pkg::*;
#(
    parameter int WC_W = 8,             // Width of the wait count.
    parameter int HC_W = 4              // Width of delay and hold counts.
) (
    input  wire logic              clk,                      // System clock.
    input  wire logic              arst_n,                   // Async reset, low.
    input  wire logic              req_valid,                // Request offered.
    output logic                   req_ready,                // Sequencer idle.
    input  wire logic              req_write,                // High for write.
    input  wire logic [31:0]       req_addr,                 // Byte address.
    input  wire logic [1:0]        req_size,                 // Size code.
    input  wire logic [127:0]      req_wdata,                // Write data, right-justified.
    output logic                   resp_valid,               // Completion pulse.
    output logic                   resp_error,               // Request not for this bank.
    output logic [127:0]           resp_rdata,               // Read data, right-justified.
    input  wire logic [2:0]        bus_type,                 // Bank bus type.
    input  wire logic              bus_width_16,             // High for 16-bit bus.
    input  wire logic              sync_mode,                // High for synchronous timing.
    input  wire logic              wait_mode_select,         // High for handshake, in sync mode only.
    input  wire logic              burst_enable,             // Line as one burst, in handshake mode only.
    input  wire logic [WC_W-1:0]   wait_count,               // Wait cycles.
    input  wire logic [HC_W-1:0]   select_delay_count,       // Select delay.
    input  wire logic [HC_W-1:0]   address_hold_count,       // Address hold.
    input  wire logic [HC_W-1:0]   data_hold_count,          // Write data hold.
    input  wire logic [HC_W-1:0]   select_hold_count,        // Select hold.
    input  wire logic [HC_W-1:0]   direction_hold_count,     // Direction hold.
    input  wire logic [HC_W-1:0]   read_enable_hold_count,   // Read enable hold.
    input  wire logic [HC_W-1:0]   write_enable_hold_count,  // Write enable hold.
    input  wire logic [31:17]      bank_base_address,        // Bank base.
    input  wire logic [31:17]      bank_match_mask,          // Bank mask.
    input  wire logic              async_bus_clock,          // Bus clock, async mode.
    output logic [31:0]            bus_address,              // Address pins.
    output logic [1:0]             transfer_size_out,        // Size pins.
    output logic [31:0]            bus_data_out,             // Data pins, out.
    output logic                   bus_data_oe_n,            // Data drive, low drives.
    input  wire logic [31:0]       bus_data_in,              // Data pins, in.
    output logic [3:0]             byte_write_enable_n,      // Lane write enables.
    output logic                   bank_select_n,            // Chip select.
    output logic                   read_enable_n,            // Read strobe.
    output logic                   read_not_write,           // High read, low write.
    input  wire logic              slave_acknowledge_n       // Slave acknowledge.
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Returns the larger of two counts.
    function automatic logic [HC_W-1:0] hmax(input logic [HC_W-1:0] a,
                                            input logic [HC_W-1:0] b);
        hmax = (a > b) ? a : b;
    endfunction : hmax

    // Returns active-low lane enables for one access.
    function automatic logic [3:0] lane_we_n(input logic       w16,
                                             input logic [1:0] sz,
                                             input logic [1:0] a);
        logic [3:0] r;
        r = 4'h0;
        if (w16) begin
            r = (sz == `SBSI_SZ_BYTE) ? (a[0] ? 4'h7 : 4'hB) : 4'h3;
        end else if (sz == `SBSI_SZ_BYTE) begin
            r = ~(4'h1 << a);
        end else if (sz == `SBSI_SZ_HALF) begin
            r = a[1] ? 4'h3 : 4'hC;
        end
        lane_we_n = r;
    endfunction : lane_we_n

    // ****************************************************************
    // Registers
    // ****************************************************************
    sbsi_state_e       state;
    logic [WC_W-1:0]   cnt;
    logic [2:0]        beat;
    logic [2:0]        last_beat;
    logic              burst;
    logic              hs;
    logic              is_write;
    logic [1:0]        size;
    logic [31:0]       base_addr;
    logic [127:0]      wdata;
    logic [127:0]      rdata;
    logic              abc_prev;
    logic              req_line_q;
    logic [2:0]        next_beat;

    // ****************************************************************
    // Decode of the incoming request
    // ****************************************************************

    // Bank decode inside the region, bus type and beat plan.
    wire in_region  = req_addr[`SBSI_REGION_HI:`SBSI_REGION_LO] == `SBSI_REGION_VAL;
    wire bank_hit   = ((req_addr[31:17] ^ bank_base_address) & bank_match_mask)
                      == 15'h0;
    wire is_sram    = bus_type == `SBSI_BT_SRAM;
    wire accept     = req_valid && req_ready;
    wire mapped     = in_region && bank_hit && is_sram;
    wire req_line   = req_size == `SBSI_SZ_LINE;
    wire req_hs     = wait_mode_select && sync_mode;
    wire [2:0] req_last = req_line ? (bus_width_16 ? `SBSI_LAST_W16 : `SBSI_LAST_W32)
                        : (bus_width_16 && req_size == `SBSI_SZ_WORD) ? `SBSI_LAST_SPLIT
                        : 3'h0;

    // ****************************************************************
    // Per-beat address, lanes and timing strobes
    // ****************************************************************

    // Bus timing tick: every clk in sync mode, a bus clock rise otherwise.
    wire tick       = sync_mode || (async_bus_clock && !abc_prev);
    wire multi      = last_beat != 3'h0;
    wire [31:0] step_off = bus_width_16 ? {28'h0, next_beat, 1'b0} : {27'h0, next_beat, 2'b0};
    wire [31:0] beat_addr = multi ? ((base_addr & (req_line_q ? 32'hFFFF_FFF0 : 32'hFFFF_FFFC))
                            + step_off) : base_addr;
    wire [1:0]  beat_size = burst ? `SBSI_SZ_LINE
                          : !multi ? size
                          : bus_width_16 ? `SBSI_SZ_HALF : `SBSI_SZ_WORD;
    wire [2:0]  wsel      = multi ? next_beat : 3'h0;
    wire [15:0] piece16   = (multi || size == `SBSI_SZ_HALF || size == `SBSI_SZ_WORD)
                            ? wdata[wsel*16 +: 16] : {2{wdata[7:0]}};
    wire [31:0] piece32   = (size == `SBSI_SZ_BYTE) ? {4{wdata[7:0]}}
                          : (size == `SBSI_SZ_HALF) ? {2{wdata[15:0]}}
                          : wdata[wsel[1:0]*32 +: 32];
    wire [31:0] beat_wdata = bus_width_16 ? {piece16, 16'h0} : piece32;
    wire [HC_W-1:0] hold_rd = hmax(hmax(address_hold_count, select_hold_count),
                                   hmax(direction_hold_count, read_enable_hold_count));
    wire [HC_W-1:0] hold_wr = hmax(hmax(hmax(address_hold_count, data_hold_count),
                                   hmax(select_hold_count, direction_hold_count)),
                                   write_enable_hold_count);
    wire [HC_W-1:0] hold_max = is_write ? hold_wr : hold_rd;
    wire [WC_W-1:0] hcnt_ext = {{(WC_W-HC_W){1'b0}}, hold_max};

    // Data phase completion: fixed count or an acknowledge once sampling starts.
    wire ack        = !slave_acknowledge_n;
    wire sampling   = cnt >= wait_count;
    wire phase_done = (state == SBSI_ACCESS) && tick &&
                      (hs ? (sampling && ack) : (cnt == wait_count));
    wire burst_more = burst && (beat != last_beat);
    wire hold_done  = (state == SBSI_HOLD) && tick && (cnt >= hcnt_ext);

    // Beat shown on the pins from this edge on, so no acknowledge sees stale data.
    assign next_beat = ((phase_done && burst_more) || (hold_done && beat != last_beat))
                       ? beat + 3'h1 : beat;

    // Read lane extraction for the data phase now completing.
    wire [15:0] rd16  = (size == `SBSI_SZ_BYTE && !multi)
                        ? {8'h0, (base_addr[0] ? bus_data_in[31:24] : bus_data_in[23:16])}
                        : bus_data_in[31:16];
    wire [31:0] rd32  = bus_data_in >> {base_addr[1:0], 3'b000};
    wire [31:0] rd_sz = (size == `SBSI_SZ_BYTE) ? {24'h0, rd32[7:0]}
                      : (size == `SBSI_SZ_HALF) ? {16'h0, rd32[15:0]} : rd32;

    assign req_ready = state == SBSI_IDLE;

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // State, counters and beat index.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= SBSI_IDLE;
            cnt   <= '0;
            beat  <= 3'h0;
        end else if (accept) begin
            state <= mapped ? SBSI_SETUP : SBSI_IDLE;
            cnt   <= '0;
            beat  <= 3'h0;
        end else if (state == SBSI_SETUP && tick) begin
            if (cnt >= {{(WC_W-HC_W){1'b0}}, select_delay_count}) begin
                state <= SBSI_ACCESS;
                cnt   <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end else if (phase_done) begin
            if (burst_more) begin
                beat <= beat + 3'h1;
            end else begin
                state <= SBSI_HOLD;
                cnt   <= '0;
            end
        end else if (hold_done) begin
            cnt <= '0;
            if (beat != last_beat) begin
                beat  <= beat + 3'h1;
                state <= SBSI_SETUP;
            end else begin
                state <= SBSI_IDLE;
            end
        end else if (state != SBSI_IDLE && tick && !(hs && state == SBSI_ACCESS
                     && sampling)) begin
            cnt <= cnt + 1'b1;
        end
    end

    // Request capture.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_beat  <= 3'h0;
            burst      <= 1'b0;
            hs         <= 1'b0;
            is_write   <= 1'b0;
            size       <= `SBSI_SZ_BYTE;
            base_addr  <= `SBSI_RST_ADDR;
            wdata      <= `SBSI_RST_LINE;
            req_line_q <= 1'b0;
        end else if (accept) begin
            burst      <= req_line && req_hs && burst_enable;
            last_beat  <= (req_line && req_hs && burst_enable) ?
                          (bus_width_16 ? `SBSI_LAST_W16 : `SBSI_LAST_W32) : req_last;
            hs         <= req_hs;
            is_write   <= req_write;
            size       <= req_size;
            base_addr  <= req_addr;
            wdata      <= req_wdata;
            req_line_q <= req_line;
        end
    end

    // Read data, response and bus clock edge tracking.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata      <= `SBSI_RST_LINE;
            resp_rdata <= `SBSI_RST_LINE;
            resp_valid <= 1'b0;
            resp_error <= 1'b0;
            abc_prev   <= 1'b0;
        end else begin
            abc_prev   <= async_bus_clock;
            resp_valid <= (accept && !mapped) || (hold_done && beat == last_beat);
            resp_error <= accept && !mapped;
            if (accept) begin
                rdata <= `SBSI_RST_LINE;
            end else if (phase_done && !is_write) begin
                if (bus_width_16) begin
                    rdata[beat*16 +: 16] <= rd16;
                end else if (multi) begin
                    rdata[beat[1:0]*32 +: 32] <= bus_data_in;
                end else begin
                    rdata[31:0] <= rd_sz;
                end
            end
            if (hold_done && beat == last_beat) begin
                resp_rdata <= rdata;
            end
        end
    end

    // ****************************************************************
    // Pin drive
    // ****************************************************************

    // Address, size and write data registered; size follows the address.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_address       <= `SBSI_RST_ADDR;
            transfer_size_out <= `SBSI_SZ_BYTE;
            bus_data_out      <= `SBSI_RST_DATA;
        end else if (state != SBSI_IDLE) begin
            bus_address       <= beat_addr;
            transfer_size_out <= beat_size;
            bus_data_out      <= beat_wdata;
        end
    end

    // Strobes from the sequencer; each negates once its own hold expires.
    wire in_acc  = state == SBSI_ACCESS;
    wire in_hold = state == SBSI_HOLD;
    wire [WC_W-1:0] csh_e = {{(WC_W-HC_W){1'b0}}, select_hold_count};
    wire [WC_W-1:0] reh_e = {{(WC_W-HC_W){1'b0}}, read_enable_hold_count};
    wire [WC_W-1:0] weh_e = {{(WC_W-HC_W){1'b0}}, write_enable_hold_count};
    wire [WC_W-1:0] dah_e = {{(WC_W-HC_W){1'b0}}, data_hold_count};
    wire [WC_W-1:0] rwh_e = {{(WC_W-HC_W){1'b0}}, direction_hold_count};
    assign bank_select_n  = !(in_acc || (in_hold && cnt < csh_e));
    assign read_enable_n  = !(!is_write && (in_acc || (in_hold && cnt < reh_e)));
    assign byte_write_enable_n = (is_write && (in_acc || (in_hold && cnt < weh_e)))
                                 ? lane_we_n(bus_width_16, size, base_addr[1:0])
                                 : 4'hF;
    assign bus_data_oe_n  = !(is_write && (state == SBSI_SETUP || in_acc ||
                              (in_hold && cnt < dah_e)));
    assign read_not_write = !(is_write && (state == SBSI_SETUP || in_acc ||
                              (in_hold && cnt < rwh_e)));

endmodule : sbsi_sram_if
`default_nettype wire

/* File: shared/sbsi_consts.svh */
// Constants for the system bus SRAM interface block.
// Assumes inclusion by the package and the design file only.
`ifndef SBSI_CONSTS_SVH
`define SBSI_CONSTS_SVH

// ********************************************************************
// Encodings and field positions
// ********************************************************************
`define SBSI_SZ_BYTE     2'h0
`define SBSI_SZ_HALF     2'h1
`define SBSI_SZ_WORD     2'h2
`define SBSI_SZ_LINE     2'h3
`define SBSI_BT_SRAM     3'h0
`define SBSI_REGION_HI   31
`define SBSI_REGION_LO   29
`define SBSI_REGION_VAL  3'h4
`define SBSI_MATCH_LO    17
`define SBSI_LAST_SPLIT  3'h1
`define SBSI_LAST_W32    3'h3
`define SBSI_LAST_W16    3'h7
`define SBSI_RST_ADDR    32'h0000_0000
`define SBSI_RST_DATA    32'h0000_0000
`define SBSI_RST_LINE    128'h0

`endif

/* File: shared/sbsi_pkg.sv */
// Types shared by the system bus SRAM interface block.
// Assumes the constants header sits beside it on the include path.
`include "sbsi_consts.svh"

package sbsi_pkg;

    // Access sequencer states.
    typedef enum logic [1:0] {
        SBSI_IDLE   = 2'b00,
        SBSI_SETUP  = 2'b01,
        SBSI_ACCESS = 2'b10,
        SBSI_HOLD   = 2'b11
    } sbsi_state_e;

endpackage : sbsi_pkg

/* File: testbench/sbsi_sram_if_bench.sv */
// Self-checking bench: random and corner requests against a reference byte store.
// Assumes the slave model's initial memory pattern and equal hold counts.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
module sbsi_sram_if_bench;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk, async_bus_clock, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic bus_width_16 = 1'b0, sync_mode = 1'b1, wait_mode_select = 1'b0, burst_enable = 1'b0;
    logic [31:0] req_addr = 32'h0, bus_address, bus_data_out, bus_data_in;
    logic [1:0] req_size = 2'h0, transfer_size_out, exp_sz;
    logic [127:0] req_wdata = 128'h0, resp_rdata;
    logic [2:0] bus_type = 3'h0;
    logic [7:0] wait_count = 8'h0, ack_gap = 8'h0, ref_mem [256];
    logic [3:0] select_delay_count = 4'h0, hold = 4'h0, byte_write_enable_n;
    logic [3:0] address_hold_count, data_hold_count, select_hold_count;
    logic [3:0] direction_hold_count, read_enable_hold_count, write_enable_hold_count;
    logic [31:17] bank_base_address = 15'h4000, bank_match_mask = 15'h7FFF;
    logic req_ready, resp_valid, resp_error, bus_data_oe_n, bank_select_n, read_enable_n;
    logic read_not_write, slave_acknowledge_n, sel_q = 1'b1, k_w16, k_sy, k_hs, k_be;
    int fail_count = 0, check_count = 0, falls = 0, k_wc, k_csd, k_h;
    assign address_hold_count = hold;
    assign data_hold_count = hold;
    assign select_hold_count = hold;
    assign direction_hold_count = hold;
    assign read_enable_hold_count = hold;
    assign write_enable_hold_count = hold;
    sbsi_sram_if dut (.*);
    sbsi_sram_slave u_slave (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        async_bus_clock = 1'b0;
        forever #6.5 async_bus_clock = ~async_bus_clock;
    end
    // Each select assertion is one bus access; its size code is checked then.
    always @(posedge clk) begin
        if (!bank_select_n && sel_q) begin
            falls++;
            `CHK("size", exp_sz, transfer_size_out)
        end
        sel_q <= bank_select_n;
    end
    // ****************************************************************
    // Tasks and functions
    // ****************************************************************
    // Expected right-justified read data from the reference store.
    function automatic logic [127:0] exp_rd(input logic [7:0] a, input int n);
        logic [127:0] r;
        r = 128'h0;
        for (int i = 0; i < n; i++) r[8*i+:8] = ref_mem[8'(a + 8'(i))];
        return r;
    endfunction : exp_rd
    task automatic cfg(input int w, s, m, b, wcv, c, hv, g);
        k_w16 = 1'(w); k_sy = 1'(s); k_hs = 1'(m); k_be = 1'(b);
        k_wc = wcv; k_csd = c; k_h = hv;
        @(posedge clk);
        bus_width_16 <= 1'(w); sync_mode <= 1'(s); wait_mode_select <= 1'(m);
        burst_enable <= 1'(b); wait_count <= 8'(wcv); select_delay_count <= 4'(c);
        hold <= 4'(hv); ack_gap <= 8'(g);
    endtask : cfg
    task automatic run(input logic wr, input logic [31:0] ad, input logic [1:0] sz,
                       input logic [127:0] wd, input logic err);
        int n, acc, cnt;
        logic bst;
        n = sz == 2'h3 ? 16 : 1 << sz;
        bst = k_be && k_hs && k_sy && sz == 2'h3;
        exp_sz = bst ? 2'h3 : (sz == 2'h3 || (k_w16 && sz == 2'h2)) ? (k_w16 ? 2'h1 : 2'h2) : sz;
        acc = err ? 0 : bst ? 1 : sz == 2'h3 ? (k_w16 ? 8 : 4) : (k_w16 && sz == 2'h2) ? 2 : 1;
        req_write <= wr; req_addr <= ad; req_size <= sz; req_wdata <= wd; req_valid <= 1'b1;
        falls = 0;
        do @(posedge clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        cnt = 0;
        do begin @(posedge clk); cnt++; end while (resp_valid !== 1'b1 && cnt < 3000);
        if (cnt >= 3000) fail_count++;
        `CHK("error", err, resp_error)
        `CHK("accesses", acc, falls)
        if (!err && acc == 1 && k_sy && !k_hs)
            `CHK("latency", 4 + k_csd + k_wc + k_h, cnt)
        if (!err && !wr)
            `CHK("rdata", exp_rd(ad[7:0], n), resp_rdata & ~({128{1'b1}} << (8 * n)))
        if (!err && wr) for (int i = 0; i < n; i++) ref_mem[8'(ad[7:0] + 8'(i))] = wd[8*i+:8];
    endtask : run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        #200000;
        fail_count++;
        stop_test();
    end
    initial begin
        logic [1:0] sz;
        for (int i = 0; i < 256; i++) ref_mem[i] = 8'(i * 3 + 1);
        void'($urandom(67));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        cfg(0, 1, 0, 0, 0, 0, 0, 0);
        run(1'b0, 32'h8000_0010, 2'h2, 128'h0, 1'b0);
        // Back-to-back acknowledges for burst lines on both widths, then a very slow slave.
        for (int w = 0; w < 2; w++) begin
            cfg(w, 1, 1, 1, 0, 0, 0, 0);
            run(1'b1, 32'h8000_0040, 2'h3, {4{$urandom}}, 1'b0);
            run(1'b0, 32'h8000_0040, 2'h3, 128'h0, 1'b0);
        end
        cfg(0, 1, 1, 0, 2, 1, 1, 40);
        run(1'b0, 32'h8000_0020, 2'h2, 128'h0, 1'b0);
        // Region miss, bank miss and a non-SRAM bus type are all refused.
        run(1'b0, 32'hA000_0000, 2'h2, 128'h0, 1'b1);
        run(1'b1, 32'h8002_0000, 2'h0, 128'h5, 1'b1);
        bus_type <= 3'h1;
        run(1'b0, 32'h8000_0000, 2'h2, 128'h0, 1'b1);
        bus_type <= 3'h0;
        for (int t = 0; t < 80; t++) begin
            cfg($urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2, $urandom % 4,
                $urandom % 3, $urandom % 3, $urandom % 3);
            sz = 2'($urandom % 4);
            run(1'($urandom % 2), 32'h8000_0000 | (($urandom % 256) & ~((sz == 2'h3 ? 16 : 1 << sz) - 1)),
                sz, {4{$urandom}}, 1'b0);
        end
        stop_test();
    end
endmodule : sbsi_sram_if_bench
`default_nettype wire

/* File: testbench/sbsi_sram_if_props.sv */
// Port-level checker for the SRAM-type system bus master.
// Assumes binding onto sbsi_sram_if and that all hold counts are set equal.
`timescale 1ns/1ps
`default_nettype none
module sbsi_sram_if_props (
    input wire logic         clk,                 // Clock.
    input wire logic         arst_n,              // Reset, low.
    input wire logic         req_valid,           // Request offered.
    input wire logic         req_ready,           // Sequencer idle.
    input wire logic [31:0]  req_addr,            // Byte address.
    input wire logic         resp_valid,          // Completion.
    input wire logic         resp_error,          // Unmapped request.
    input wire logic [2:0]   bus_type,            // Bank bus type.
    input wire logic         bus_width_16,        // 16-bit bus.
    input wire logic         sync_mode,           // Synchronous timing.
    input wire logic         wait_mode_select,    // Handshake.
    input wire logic         burst_enable,        // Burst lines.
    input wire logic [31:17] bank_base_address,   // Bank base.
    input wire logic [31:17] bank_match_mask,     // Bank mask.
    input wire logic [1:0]   transfer_size_out,   // Size pins.
    input wire logic         bus_data_oe_n,       // Data drive, low drives.
    input wire logic [3:0]   byte_write_enable_n, // Lane enables.
    input wire logic         bank_select_n,       // Chip select.
    input wire logic         read_enable_n,       // Read strobe.
    input wire logic         read_not_write       // Direction.
);
    // ****************************************************************
    // Decode and sequences
    // ****************************************************************
    // A request hits when it lies in the region, matches the bank and the bank is SRAM type.
    wire logic hit = req_addr[31:29] == 3'h4 && bus_type == 3'h0 &&
        (req_addr[31:17] & bank_match_mask) == (bank_base_address & bank_match_mask);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_take_hit; req_valid && req_ready && hit; endsequence
    sequence s_take_miss; req_valid && req_ready && !hit; endsequence
    sequence s_err_answer; ##[1:2] (resp_valid && resp_error); endsequence
    sequence s_select_soon; ##[2:80] !bank_select_n; endsequence
    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Decode outcome and answer of each request.
    chk_miss_error: assert property (s_take_miss |-> s_err_answer)
        else $error("unmapped request not answered with error");
    chk_hit_select: assert property (s_take_hit |-> s_select_soon)
        else $error("mapped request never selected the bank");
    chk_hit_no_err: assert property (s_take_hit |=> !resp_error [*3])
        else $error("mapped request answered with error");
    // Bus strobes and pins against mode and direction.
    chk_idle_quiet: assert property (req_ready |-> bank_select_n && read_enable_n
        && byte_write_enable_n == 4'hF && bus_data_oe_n) else $error("strobe active while idle");
    chk_size_steady: assert property (!bank_select_n && $past(!bank_select_n)
        |-> $stable(transfer_size_out)) else $error("size changed inside an access");
    chk_w16_lanes: assert property (bus_width_16 |-> byte_write_enable_n[1:0] == 2'h3)
        else $error("low lanes enabled on 16-bit bus");
    chk_w16_size: assert property (bus_width_16 && !bank_select_n
        |-> transfer_size_out != 2'h2) else $error("word size on 16-bit bus");
    chk_burst_mode: assert property (!bank_select_n && transfer_size_out == 2'h3
        |-> wait_mode_select && sync_mode && burst_enable) else $error("burst outside burst mode");
    chk_read_no_drive: assert property (!read_enable_n |-> bus_data_oe_n && read_not_write)
        else $error("device drives data during read");
    chk_we_is_write: assert property (byte_write_enable_n != 4'hF
        |-> !read_not_write && !bank_select_n) else $error("write enable outside write");
    chk_resp_single: assert property (resp_valid |=> !resp_valid)
        else $error("completion longer than one cycle");
endmodule : sbsi_sram_if_props
bind sbsi_sram_if sbsi_sram_if_props u_props (.*);
`default_nettype wire

/* File: testbench/sbsi_sram_slave.sv */
// Behavioural SRAM slave with handshake acknowledge for the bus master.
// Assumes synchronous acknowledge and data valid whenever read enable is low.
`timescale 1ns/1ps
`default_nettype none
module sbsi_sram_slave (
    input  wire logic        clk,                 // Clock.
    input  wire logic        bus_width_16,        // 16-bit bus.
    input  wire logic [7:0]  ack_gap,             // Idle cycles between acknowledges.
    input  wire logic [31:0] bus_address,         // Address pins.
    input  wire logic [31:0] bus_data_out,        // Write data pins.
    input  wire logic [3:0]  byte_write_enable_n, // Lane enables.
    input  wire logic        bank_select_n,       // Chip select.
    input  wire logic        read_enable_n,       // Read strobe.
    output logic [31:0]      bus_data_in,         // Read data pins.
    output logic             slave_acknowledge_n  // Acknowledge, low.
);
    // ****************************************************************
    // Storage and lanes
    // ****************************************************************
    logic [7:0]  mem [256];
    logic [7:0]  gap_cnt;
    logic [31:0] rd_q;
    wire  logic [7:0] base = bus_width_16 ? {bus_address[7:1], 1'b0} - 8'h2 : {bus_address[7:2], 2'h0};
    wire  logic [31:0] rd = {mem[base + 8'h3], mem[base + 8'h2], mem[base + 8'h1], mem[base]};
    // Lane k holds byte base+k; released lines show the inverse of the last value.
    assign bus_data_in = !read_enable_n ? rd : ~rd_q;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 3 + 1);
        rd_q = 32'h0;
        gap_cnt = 8'h0;
        slave_acknowledge_n = 1'b1;
    end
    // Enabled lanes are stored; acknowledge requests the next beat after the chosen gap.
    always @(posedge clk) begin
        for (int k = 0; k < 4; k++)
            if (!bank_select_n && !byte_write_enable_n[k]) mem[base + 8'(k)] <= bus_data_out[8*k+:8];
        if (!read_enable_n) rd_q <= rd;
        if (bank_select_n || gap_cnt < ack_gap) begin
            slave_acknowledge_n <= 1'b1;
            gap_cnt <= bank_select_n ? 8'h0 : gap_cnt + 8'h1;
        end else begin
            slave_acknowledge_n <= 1'b0;
            gap_cnt <= 8'h0;
        end
    end
endmodule : sbsi_sram_slave
`default_nettype wire
